// File: hw/cpb_map.vh
// register map, field positions and reset values for the
// channel 3 pin-d select and complementary pwm cycle/buffer block.
// assumes a 32-bit avalon-mm slave with word-aligned registers.
`ifndef CPB_MAP_VH
`define CPB_MAP_VH
// --------------------------------------------------------------
// register word offsets
// --------------------------------------------------------------
`define CPB_OFS_IOCTL     4'h0
`define CPB_OFS_MODE      4'h1
`define CPB_OFS_CYCBUF    4'h2
`define CPB_OFS_CARBUF    4'h3
`define CPB_OFS_XFER      4'h4
`define CPB_OFS_SKIP      4'h5
`define CPB_OFS_LIMITS    4'h6
`define CPB_OFS_GRD       4'h7
`define CPB_OFS_STATUS    4'h8
`define CPB_OFS_MASK      4'h9
// --------------------------------------------------------------
// fields
// --------------------------------------------------------------
`define CPB_IOD_MSB       7
`define CPB_IOD_LSB       4
`define CPB_MODE_BUFD     4
`define CPB_MODE_TT_MSB   3
`define CPB_TT_CREST      4'hE
`define CPB_TT_TROUGH     4'hD
`define CPB_TT_BOTH       4'hF
`define CPB_SKIP_A_EN     7
`define CPB_SKIP_V_EN     3
`define CPB_ST_MATCH      0
`define CPB_ST_CAPT       1
`define CPB_ST_XFER       2
// --------------------------------------------------------------
// reset values
// --------------------------------------------------------------
`define CPB_RST_IOCTL     8'h00
`define CPB_RST_MODE      8'h00
`define CPB_RST_CYC       16'hFFFF
`endif

// File: hw/cpb_pin_d.v
// channel 3 pin-d select: compare output or input capture.
// assumes match and pin inputs already synchronous to mclk.
`include "cpb_map.vh"
module cpb_pin_d (
    // clock and reset
    input  wire        mclk,
    input  wire        rst_n,
    // control
    input  wire [3:0]  iod_sel,
    input  wire        sel_wr,
    input  wire        buf_mode,
    // events
    input  wire        cmp_match,
    input  wire        pin_in,
    // results
    output reg         pin_out_ff,
    output wire        capture,
    output wire        match_evt
);
    reg pin_prev_ff;
    wire rise = pin_in & ~pin_prev_ff;
    wire fall = ~pin_in & pin_prev_ff;
    wire cmp_mode = ~iod_sel[3] & ~buf_mode;
    reg  cap_hit;
    reg  nxt_pin;

    // --------------------------------------------------------------
    // capture edge select
    // --------------------------------------------------------------
    always @* begin
        case (iod_sel[1:0])
            2'h0:    cap_hit = rise;
            2'h1:    cap_hit = fall;
            default: cap_hit = rise | fall;
        endcase
    end
    assign capture   = iod_sel[3] & ~buf_mode & cap_hit;
    assign match_evt = cmp_mode & cmp_match;

    // compare output; initial level loaded when a compare select other than retain is written
    always @* begin
        nxt_pin = pin_out_ff;
        if (sel_wr && !iod_sel[3] && iod_sel[1:0] != 2'h0) begin
            nxt_pin = iod_sel[2];
        end else if (match_evt) begin
            case (iod_sel[1:0])
                2'h1:    nxt_pin = 1'b0;
                2'h2:    nxt_pin = 1'b1;
                2'h3:    nxt_pin = ~pin_out_ff;
                default: nxt_pin = pin_out_ff;
            endcase
        end
    end

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pin_out_ff  <= 1'b0;
            pin_prev_ff <= 1'b0;
        end else begin
            pin_out_ff  <= nxt_pin;
            pin_prev_ff <= pin_in;
        end
    end
endmodule

// File: hw/cpb_top.v
// complementary pwm cycle and buffer-transfer control with pin-d select.
// counters, dead-time and skip counters live elsewhere in the timer;
// this block sees their crest/trough/window strobes as mclk inputs.
//
// The register offsets and the Avalon-MM interface to the registers are this design's own decisions.
`include "cpb_map.vh"
module cpb_top #(
    parameter W = 16
) (
    // clock and reset
    input  wire         mclk,
    input  wire         resetn,
    // avalon-mm slave
    input  wire [3:0]   address,
    input  wire         read,
    input  wire         write,
    input  wire [31:0]  writedata,
    output reg  [31:0]  readdata,
    output wire         waitrequest,
    // timer events, same clock
    input  wire         crest,
    input  wire         trough,
    input  wire         skip_window,
    input  wire         grd_match,
    input  wire [W-1:0] grd_counter,
    // pin d
    input  wire         pin_d_in,
    output wire         pin_d_out,
    output wire         pin_d_oe_n,
    // cycle limits to counters and temp copy strobe
    output reg  [W-1:0] ch3_limit_ff,
    output reg  [W-1:0] ch4_limit_ff,
    output wire         temp_copy,
    // interrupt
    output wire         irq
);
    // --------------------------------------------------------------
    // reset and pin synchronisers
    // --------------------------------------------------------------
    reg rs1_ff, rs2_ff;
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rs1_ff <= 1'b0;
            rs2_ff <= 1'b0;
        end else begin
            rs1_ff <= 1'b1;
            rs2_ff <= rs1_ff;
        end
    end
    wire rst_n = rs2_ff;

    reg pin_s1_ff, pin_s2_ff;
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1_ff <= 1'b0;
            pin_s2_ff <= 1'b0;
        end else begin
            pin_s1_ff <= pin_d_in;
            pin_s2_ff <= pin_s1_ff;
        end
    end

    // --------------------------------------------------------------
    // registers
    // --------------------------------------------------------------
    reg [7:0]   ioctl_ff, mode_ff, skip_ff;
    reg [1:0]   xfer_ff;
    reg [W-1:0] cycbuf_ff, carbuf_ff, grd_ff;
    reg [2:0]   stat_ff, mask_ff;
    reg         ack_ff;

    // one wait state: request answered on the second edge
    wire req = (read | write) & ~ack_ff;
    assign waitrequest = (read | write) & ~ack_ff;
    wire wr_en = write & ack_ff;
    wire rd_en = read & ack_ff;

    function sel;
        input [3:0] a;
        input [3:0] o;
        sel = (a == o);
    endfunction

    wire iod_wr = wr_en & sel(address, `CPB_OFS_IOCTL);

    // --------------------------------------------------------------
    // transfer decision
    // --------------------------------------------------------------
    wire [3:0] tt   = mode_ff[`CPB_MODE_TT_MSB:0];
    wire at_crest   = (tt == `CPB_TT_CREST || tt == `CPB_TT_BOTH) & crest;
    wire at_trough  = (tt == `CPB_TT_TROUGH || tt == `CPB_TT_BOTH) & trough;
    wire xfer_point = at_crest | at_trough;
    // window needs an enable with a nonzero count on that enable
    wire skip_a     = skip_ff[`CPB_SKIP_A_EN] & (skip_ff[6:4] != 3'h0);
    wire skip_v     = skip_ff[`CPB_SKIP_V_EN] & (skip_ff[2:0] != 3'h0);
    wire skip_on    = skip_a | skip_v;
    reg  xfer_ok;
    always @* begin
        case (xfer_ff)
            2'h1:    xfer_ok = 1'b0;
            2'h2:    xfer_ok = skip_on & skip_window;
            default: xfer_ok = 1'b1;
        endcase
    end
    assign temp_copy = xfer_point & xfer_ok;

    // crest waits for the next trough, trough takes effect in the current one
    reg pend_ff;
    reg [W-1:0] pend3_ff, pend4_ff;
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ch3_limit_ff <= `CPB_RST_CYC;
            ch4_limit_ff <= `CPB_RST_CYC;
            pend_ff      <= 1'b0;
            pend3_ff     <= `CPB_RST_CYC;
            pend4_ff     <= `CPB_RST_CYC;
        end else if (xfer_point && at_trough) begin
            ch3_limit_ff <= cycbuf_ff;
            ch4_limit_ff <= carbuf_ff;
            pend_ff      <= 1'b0;
        end else if (xfer_point) begin
            pend3_ff     <= cycbuf_ff;
            pend4_ff     <= carbuf_ff;
            pend_ff      <= 1'b1;
        end else if (pend_ff && trough) begin
            ch3_limit_ff <= pend3_ff;
            ch4_limit_ff <= pend4_ff;
            pend_ff      <= 1'b0;
        end
    end

    // --------------------------------------------------------------
    // pin d
    // --------------------------------------------------------------
    wire cap_evt, match_evt;
    // a select write must load the new initial level, not the old one
    wire [3:0] iod_sel_now = iod_wr ? writedata[7:4]
                                    : ioctl_ff[`CPB_IOD_MSB:`CPB_IOD_LSB];
    cpb_pin_d u_pin (
        .mclk       (mclk),
        .rst_n      (rst_n),
        .iod_sel    (iod_sel_now),
        .sel_wr     (iod_wr),
        .buf_mode   (mode_ff[`CPB_MODE_BUFD]),
        .cmp_match  (grd_match),
        .pin_in     (pin_s2_ff),
        .pin_out_ff (pin_d_out),
        .capture    (cap_evt),
        .match_evt  (match_evt)
    );
    // driven while compare; low enable means driving
    assign pin_d_oe_n = ioctl_ff[`CPB_IOD_MSB];

    // --------------------------------------------------------------
    // register writes, status and capture
    // --------------------------------------------------------------
    wire [2:0] ev = {temp_copy, cap_evt, match_evt};
    wire st_rd = rd_en & sel(address, `CPB_OFS_STATUS);
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ack_ff    <= 1'b0;
            ioctl_ff  <= `CPB_RST_IOCTL;
            mode_ff   <= `CPB_RST_MODE;
            skip_ff   <= 8'h00;
            xfer_ff   <= 2'h0;
            cycbuf_ff <= `CPB_RST_CYC;
            carbuf_ff <= `CPB_RST_CYC;
            grd_ff    <= {W{1'b0}};
            stat_ff   <= 3'h0;
            mask_ff   <= 3'h0;
        end else begin
            ack_ff <= req;
            if (iod_wr)
                ioctl_ff <= writedata[7:0];
            if (wr_en && sel(address, `CPB_OFS_MODE))
                mode_ff <= writedata[7:0];
            if (wr_en && sel(address, `CPB_OFS_SKIP))
                skip_ff <= writedata[7:0];
            if (wr_en && sel(address, `CPB_OFS_XFER))
                xfer_ff <= writedata[1:0];
            // buffers are always writable
            if (wr_en && sel(address, `CPB_OFS_CYCBUF))
                cycbuf_ff <= writedata[W-1:0];
            if (wr_en && sel(address, `CPB_OFS_CARBUF))
                carbuf_ff <= writedata[W-1:0];
            if (wr_en && sel(address, `CPB_OFS_MASK))
                mask_ff <= writedata[2:0];
            if (cap_evt)
                grd_ff <= grd_counter;
            else if (wr_en && sel(address, `CPB_OFS_GRD))
                grd_ff <= writedata[W-1:0];
            // set wins over clear-on-read
            stat_ff <= (st_rd ? 3'h0 : stat_ff) | ev;
        end
    end
    assign irq = |(stat_ff & mask_ff);

    // --------------------------------------------------------------
    // read mux, registered with the acknowledge
    // --------------------------------------------------------------
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            readdata <= 32'h0;
        end else if (read && req) begin
            case (address)
                `CPB_OFS_IOCTL:  readdata <= {24'h0, ioctl_ff};
                `CPB_OFS_MODE:   readdata <= {24'h0, mode_ff};
                `CPB_OFS_CYCBUF: readdata <= {{(32-W){1'b0}}, cycbuf_ff};
                `CPB_OFS_CARBUF: readdata <= {{(32-W){1'b0}}, carbuf_ff};
                `CPB_OFS_XFER:   readdata <= {30'h0, xfer_ff};
                `CPB_OFS_SKIP:   readdata <= {24'h0, skip_ff};
                `CPB_OFS_LIMITS: readdata <= {ch4_limit_ff, ch3_limit_ff};
                `CPB_OFS_GRD:    readdata <= {{(32-W){1'b0}}, grd_ff};
                `CPB_OFS_STATUS: readdata <= {29'h0, stat_ff};
                `CPB_OFS_MASK:   readdata <= {29'h0, mask_ff};
                default:         readdata <= 32'h0;
            endcase
        end
    end
endmodule

// File: dv/cpb_monitor.sv
// checker for the pin-d select and cycle/buffer block, bound to top.
// assumes one clock and writes that land when waitrequest is low.
module cpb_monitor #(parameter W = 16) (
    // clock and reset
    input wire         mclk,
    input wire         resetn,
    // register bus
    input wire [3:0]   address,
    input wire         read,
    input wire         write,
    input wire [31:0]  writedata,
    input wire         waitrequest,
    // events and outputs
    input wire         trough,
    input wire         skip_window,
    input wire         grd_match,
    input wire         pin_d_out,
    input wire         pin_d_oe_n,
    input wire [W-1:0] ch3_limit_ff,
    input wire         temp_copy,
    input wire         irq
);
    reg [7:0]  sh_ff [0:9];
    reg        io_set_ff;
    integer    i;
    wire [7:0] sk = sh_ff[5];
    wire [1:0] xf = sh_ff[4][1:0];
    wire       skip_off = !(sk[7] | sk[3]) | (sk[6:4] == 3'h0 & sk[2:0] == 3'h0);
    // shadow of each written register, since the bodies are hidden
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            for (i = 0; i < 10; i = i + 1)
                sh_ff[i] <= 8'h00;
            io_set_ff <= 1'b0;
        end else if (write && !waitrequest && address < 4'hA) begin
            sh_ff[address] <= writedata[7:0];
            io_set_ff <= io_set_ff | (address == 4'h0);
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);
    // ----------
    // assertions
    // ----------
    chk_one_wait:
        assert property ((read | write) & waitrequest |=> !waitrequest)
        else $error("access held beyond one wait state");
    chk_pin_reset:
        assert property (!io_set_ff |-> !pin_d_out)
        else $error("pin d not low before first select write");
    chk_oe_select:
        assert property ($stable(sh_ff[0][7]) |-> pin_d_oe_n == sh_ff[0][7])
        else $error("pin d enable disagrees with select");
    chk_match_high:
        assert property (grd_match & sh_ff[0][7:4] == 4'h2 & !sh_ff[1][4]
            |-> ##[1:3] pin_d_out)
        else $error("compare match did not drive pin high");
    chk_copy_off:
        assert property (xf == 2'b01 |-> !temp_copy)
        else $error("copy while transfer suppressed");
    chk_copy_skip:
        assert property (xf == 2'b10 & skip_off |-> !temp_copy)
        else $error("linked copy while skipping disabled");
    chk_copy_win:
        assert property (xf == 2'b10 & temp_copy
            |-> skip_window | $past(skip_window))
        else $error("linked copy outside window");
    chk_irq_mask:
        assert property ($stable(sh_ff[9]) & sh_ff[9] == 8'h00 |-> !irq)
        else $error("interrupt with all sources masked");
    chk_limit_trough:
        assert property ($changed(ch3_limit_ff) |-> $past(trough)
            | $past(trough, 2))
        else $error("limit changed away from a trough");
    cov_copy: cover property (temp_copy);
    cov_irq: cover property (irq);
    cov_limit: cover property ($changed(ch3_limit_ff));
endmodule

bind cpb_top cpb_monitor #(.W(W)) u_mon (
    .mclk(mclk), .resetn(resetn), .address(address), .read(read),
    .write(write), .writedata(writedata), .waitrequest(waitrequest),
    .trough(trough), .skip_window(skip_window), .grd_match(grd_match),
    .pin_d_out(pin_d_out), .pin_d_oe_n(pin_d_oe_n),
    .ch3_limit_ff(ch3_limit_ff), .temp_copy(temp_copy), .irq(irq));

// File: dv/tb.sv
// self-checking bench for the pin-d select and cycle/buffer block.
// assumes every register access is answered after one wait state.
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    reg         mclk, resetn, read, write, crest, trough;
    reg         skip_window, grd_match, pin_d_in;
    reg  [3:0]  address;
    reg  [31:0] writedata, q;
    wire [31:0] readdata;
    wire [15:0] ch3_l, ch4_l;
    wire        waitrequest, pin_d_out, pin_d_oe_n, temp_copy, irq;
    integer     fails, checks, copies, k;
    cpb_top #(.W(16)) u_dut (
        .mclk(mclk), .resetn(resetn), .address(address), .read(read),
        .write(write), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .crest(crest), .trough(trough),
        .skip_window(skip_window), .grd_match(grd_match),
        .grd_counter(16'h1234), .pin_d_in(pin_d_in),
        .pin_d_out(pin_d_out), .pin_d_oe_n(pin_d_oe_n),
        .ch3_limit_ff(ch3_l), .ch4_limit_ff(ch4_l),
        .temp_copy(temp_copy), .irq(irq));
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    // copy strobes are counted here so a scenario can ask for none
    always @(posedge mclk) if (temp_copy === 1'b1) copies = copies + 1;
    // -----
    // tasks
    // -----
    task chk(input [31:0] got, input [31:0] exp);
        begin
            checks = checks + 1;
            if (got !== exp) begin
                fails = fails + 1;
                $display("ERROR %0t got %h want %h", $time, got, exp);
            end
        end
    endtask
    task end_of_test;
        begin
            $display("checks %0d fails %0d", checks, fails);
            if (fails == 0 && checks > 0)
                $display("== PASSED ==");
            else
                $display("== FAILED ==");
            $finish;
        end
    endtask
    // request held until waitrequest is seen low before a rising edge
    task bus(input w, input [3:0] a, input [31:0] d);
        integer n;
        begin
            @(posedge mclk);
            address <= a;
            writedata <= d;
            write <= w;
            read <= !w;
            n = 0;
            @(posedge mclk);
            while (waitrequest !== 1'b0 && n < 20) begin
                n = n + 1;
                @(posedge mclk);
            end
            if (n == 20) begin
                fails = fails + 1;
                end_of_test;
            end
            q = readdata;
            read <= 1'b0;
            write <= 1'b0;
            // outputs are judged once the edge has settled
            @(negedge mclk);
        end
    endtask
    task ev(input c, input t, input m);
        begin
            @(posedge mclk);
            crest <= c;
            trough <= t;
            grd_match <= m;
            @(posedge mclk);
            crest <= 1'b0;
            trough <= 1'b0;
            grd_match <= 1'b0;
            repeat (3) @(posedge mclk);
        end
    endtask
    // skip settings go in before the transfer bits, never the reverse
    task cp(input [7:0] x, input [7:0] s, input win, input e);
        begin
            bus(1, 4'h5, {24'h0, s});
            bus(1, 4'h4, {24'h0, x});
            skip_window <= win;
            copies = 0;
            ev(1, 0, 0);
            ev(0, 1, 0);
            chk(copies != 0, e);
        end
    endtask
    initial begin
        {resetn, read, write, crest, trough} = 5'h00;
        {skip_window, grd_match, pin_d_in} = 3'h0;
        address = 4'h0;
        writedata = 32'h0;
        fails = 0;
        checks = 0;
        copies = 0;
        repeat (20) @(posedge mclk);
        resetn <= 1'b1;
        repeat (3) @(posedge mclk);
        chk(pin_d_out, 1'b0);
        chk(ch3_l, 16'hFFFF);
        bus(0, 4'h0, 0);
        chk(q, 32'h0);
        bus(1, 4'hF, 32'h5A);
        bus(0, 4'hF, 0);
        chk(q, 32'h0);
        $display("reset done");
        // every compare code except retain: initial level, then match
        for (k = 1; k < 8; k = k + 1) if (k != 4) begin
            bus(1, 4'h0, k << 4);
            repeat (2) @(posedge mclk);
            chk(pin_d_out, k[2]);
            chk(pin_d_oe_n, 1'b0);
            ev(0, 0, 1);
            chk(pin_d_out, k[1:0] == 2'b11 ? !k[2] : k[1]);
        end
        $display("compare done");
        bus(0, 4'h8, 0);
        bus(1, 4'h9, 32'h2);
        bus(1, 4'h0, 32'h90);
        chk(pin_d_oe_n, 1'b1);
        pin_d_in <= 1'b1;
        repeat (6) @(posedge mclk);
        chk(irq, 1'b0);
        pin_d_in <= 1'b0;
        repeat (6) @(posedge mclk);
        chk(irq, 1'b1);
        bus(0, 4'h7, 0);
        chk(q, 32'h1234);
        bus(0, 4'h8, 0);
        chk(q[1], 1'b1);
        chk(irq, 1'b0);
        bus(1, 4'h9, 0);
        bus(1, 4'h0, 32'hA0);
        pin_d_in <= 1'b1;
        repeat (6) @(posedge mclk);
        chk(irq, 1'b0);
        bus(0, 4'h8, 0);
        chk(q[1], 1'b1);
        $display("capture done");
        bus(1, 4'h0, 32'h20);
        bus(1, 4'h1, 32'h10);
        bus(0, 4'h8, 0);
        ev(0, 0, 1);
        chk(pin_d_out, 1'b0);
        bus(0, 4'h8, 0);
        chk(q[0], 1'b0);
        $display("buffer mode done");
        // cycle pairs keep ch3 limit = carrier + 1, no dead time
        bus(1, 4'h1, 32'h0D);
        bus(1, 4'h2, 32'h100);
        bus(1, 4'h3, 32'hFF);
        ev(0, 1, 0);
        chk({ch4_l, ch3_l}, 32'h00FF0100);
        bus(1, 4'h1, 32'h0E);
        bus(1, 4'h2, 32'h200);
        bus(1, 4'h3, 32'h1FF);
        ev(1, 0, 0);
        chk(ch3_l, 16'h0100);
        ev(0, 1, 0);
        chk({ch4_l, ch3_l}, 32'h01FF0200);
        bus(0, 4'h6, 0);
        chk(q, 32'h01FF0200);
        $display("cycle done");
        bus(1, 4'h1, 32'h0F);
        cp(8'h00, 8'h00, 1'b0, 1'b1);
        cp(8'h01, 8'h99, 1'b1, 1'b0);
        cp(8'h02, 8'h00, 1'b1, 1'b0);
        cp(8'h02, 8'h80, 1'b1, 1'b0);
        cp(8'h02, 8'h90, 1'b0, 1'b0);
        cp(8'h02, 8'h90, 1'b1, 1'b1);
        cp(8'h02, 8'h09, 1'b1, 1'b1);
        $display("transfer done");
        end_of_test;
    end
endmodule
